// ==== hw/pcc_pkg.sv ====
// package of constants and types for the 16-bit card control-signal block
package pcc_pkg;
	// socket interface personality
	typedef enum logic [0:0] {
		PCC_IF_MEMORY = 1'b0, // memory-only card
		PCC_IF_IO = 1'b1 // i/o card
	} pcc_if_t;
	// cycle sequencer states
	typedef enum logic [2:0] {
		PCC_ST_IDLE = 3'b000, // no cycle
		PCC_ST_SETUP = 3'b001, // address and select settle
		PCC_ST_STROBE = 3'b010, // strobe active, minimum width
		PCC_ST_WAIT = 3'b011, // strobe held while card waits
		PCC_ST_HOLD = 3'b100 // strobe released, hold time
	} pcc_state_t;
	// cycle kinds on the request port
	typedef enum logic [2:0] {
		PCC_CYC_MEM_RD = 3'b000, // common memory read
		PCC_CYC_MEM_WR = 3'b001, // common memory write
		PCC_CYC_ATTR_RD = 3'b010, // attribute memory read
		PCC_CYC_ATTR_WR = 3'b011, // attribute memory write
		PCC_CYC_IO_RD = 3'b100, // i/o read
		PCC_CYC_IO_WR = 3'b101, // i/o write
		PCC_CYC_DMA_TO_HOST = 3'b110, // dma card to host memory
		PCC_CYC_DMA_TO_CARD = 3'b111 // dma host memory to card
	} pcc_cycle_t;
	// voltage requirement decoded from the two sense lines
	typedef enum logic [1:0] {
		PCC_VOLT_5V = 2'b00, // both sense lines open
		PCC_VOLT_3V3 = 2'b01, // sense one grounded
		PCC_VOLT_LOW = 2'b10, // sense two grounded, low-voltage card
		PCC_VOLT_BOTH = 2'b11 // both grounded
	} pcc_volt_t;
	// timing figures in ns, cycle counts derived at 50 mhz
	localparam int PCC_CLK_NS = 20;
	localparam int PCC_SETUP_NS = 60;
	localparam int PCC_STROBE_NS = 150;
	localparam int PCC_HOLD_NS = 40;
	localparam int PCC_SETUP_CYC = (PCC_SETUP_NS + PCC_CLK_NS - 1) / PCC_CLK_NS;
	localparam int PCC_STROBE_CYC = (PCC_STROBE_NS + PCC_CLK_NS - 1) / PCC_CLK_NS;
	localparam int PCC_HOLD_CYC = (PCC_HOLD_NS + PCC_CLK_NS - 1) / PCC_CLK_NS;
	localparam int PCC_CNT_W = 4;
	localparam logic [PCC_CNT_W-1:0] PCC_CNT_ZERO = 4'h0;
	localparam logic [PCC_CNT_W-1:0] PCC_CNT_ONE = 4'h1;
	localparam logic [1:0] PCC_SYNC_RESET = 2'h3; // card lines idle high
endpackage : pcc_pkg

// ==== hw/pcc_ctrl.sv ====
// control-signal sequencer for a 16-bit memory or i/o card socket
`timescale 1ns/10ps
module pcc_ctrl
	import pcc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en, // freezes all state while low
	input wire logic if_mode, // socket personality, pcc_if_t coding
	input wire logic card_reset_req, // software wants the card in reset
	input wire logic cyc_req, // start a cycle, taken while cyc_ready
	input wire logic [2:0] cyc_kind, // pcc_cycle_t coding
	input wire logic cyc_last, // last dma transfer to the card: raise terminal count
	output logic cyc_ready, // sequencer can take a request
	output logic cyc_done, // one-cycle pulse at cycle end
	input wire logic ready_irq_pin, // shared ready / interrupt, raw pin
	input wire logic wait_n_pin, // raw card wait, active low
	input wire logic wp_pin, // raw write-protect / 16-bit / dma request
	input wire logic voltage_sense_one_in, // raw sense line one, input side
	input wire logic voltage_sense_two_in, // raw sense line two, input side
	output logic voltage_sense_one_out, // sense one drive value (low)
	output logic voltage_sense_one_oe, // low while driving
	output logic voltage_sense_two_out, // sense two drive value (low)
	output logic voltage_sense_two_oe, // low while driving
	output logic attr_sel_n, // attribute select / dma_acknowledge, active low
	output logic oe_n, // output enable strobe
	output logic we_n, // write strobe / terminal_count
	output logic io_read_strobe_n, // i/o read, dma write strobe
	output logic io_write_strobe_n, // i/o write, dma read strobe
	output logic card_reset, // hard reset to card, active high
	output logic card_busy, // memory card busy
	output logic card_interrupt_request, // i/o card wants service
	output logic write_protected, // memory card switch state
	output logic wide_io_port_indicator, // addressed i/o port is 16 bit
	output logic dma_request, // card asks for dma
	output logic [1:0] card_voltage // pcc_volt_t coding
);

	// synchroniser stages, first stage read only by the second
	logic [1:0] rdy_sync_reg; // ready/irq
	logic [1:0] wait_sync_reg; // wait
	logic [1:0] wp_sync_reg; // write-protect
	logic [1:0] vs1_sync_reg; // sense one
	logic [1:0] vs2_sync_reg; // sense two

	// sequencer state
	pcc_state_t state_reg, state_next;
	logic [PCC_CNT_W-1:0] cnt_reg, cnt_next;
	logic [2:0] kind_reg; // latched cycle kind
	logic last_reg; // latched terminal count request
	logic reset_reg; // registered card reset
	// registered strobes so pins come from flip-flops
	logic attr_n_reg, oe_n_reg, we_n_reg, io_read_strobe_n_reg, io_write_strobe_n_reg;

	// synchronise every card input before control logic sees it
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rdy_sync_reg <= PCC_SYNC_RESET;
			wait_sync_reg <= PCC_SYNC_RESET;
			wp_sync_reg <= PCC_SYNC_RESET;
			vs1_sync_reg <= PCC_SYNC_RESET;
			vs2_sync_reg <= PCC_SYNC_RESET;
		end
		else if (clk_en)
		begin
			rdy_sync_reg <= {rdy_sync_reg[0], ready_irq_pin};
			wait_sync_reg <= {wait_sync_reg[0], wait_n_pin};
			wp_sync_reg <= {wp_sync_reg[0], wp_pin};
			vs1_sync_reg <= {vs1_sync_reg[0], voltage_sense_one_in};
			vs2_sync_reg <= {vs2_sync_reg[0], voltage_sense_two_in};
		end
	end

	// synchronised levels
	wire rdy_s = rdy_sync_reg[1];
	wire wait_s = ~wait_sync_reg[1]; // true while card stretches
	wire wp_s = wp_sync_reg[1];
	wire io_mode = (if_mode == PCC_IF_IO);

	// shared ready line meaning depends on personality
	assign card_busy = ~io_mode & ~rdy_s;
	assign card_interrupt_request = io_mode & ~rdy_s;
	// write-protect pin meaning: switch, wide port, or dma request
	assign write_protected = ~io_mode & wp_s;
	assign wide_io_port_indicator = io_mode & ~wp_s;
	assign dma_request = wp_s;
	// sense lines read as one code, never separately
	assign card_voltage = {~vs2_sync_reg[1], ~vs1_sync_reg[1]};
	// sense lines are inputs here; output enable high releases them
	assign voltage_sense_one_out = 1'b0;
	assign voltage_sense_one_oe = 1'b1;
	assign voltage_sense_two_out = 1'b0;
	assign voltage_sense_two_oe = 1'b1;

	// request decode
	function automatic logic kind_is_dma(input logic [2:0] k);
		kind_is_dma = (k == PCC_CYC_DMA_TO_HOST) || (k == PCC_CYC_DMA_TO_CARD);
	endfunction : kind_is_dma

	// memory cards stay busy until ready rises; no new cycle before then
	wire card_can_accept = io_mode | rdy_s;
	assign cyc_ready = (state_reg == PCC_ST_IDLE) & card_can_accept & ~reset_reg;
	wire take = cyc_req & cyc_ready;
	wire [2:0] kind_now = kind_reg;
	wire is_dma = kind_is_dma(kind_now);
	wire is_attr = (kind_now == PCC_CYC_ATTR_RD) || (kind_now == PCC_CYC_ATTR_WR);
	wire is_io = (kind_now == PCC_CYC_IO_RD) || (kind_now == PCC_CYC_IO_WR);
	wire is_mem_rd = (kind_now == PCC_CYC_MEM_RD) || (kind_now == PCC_CYC_ATTR_RD);
	wire is_mem_wr = (kind_now == PCC_CYC_MEM_WR) || (kind_now == PCC_CYC_ATTR_WR);
	wire active = (state_reg != PCC_ST_IDLE);
	wire strobing = (state_reg == PCC_ST_STROBE) || (state_reg == PCC_ST_WAIT);

	// attribute select low for attribute, i/o and dma acknowledge, high for common memory
	wire attr_n_next = ~(active & (is_attr | is_io | is_dma));
	// output enable for memory and attribute reads
	wire oe_n_next = ~(strobing & is_mem_rd);
	// write strobe for memory and attribute writes, or terminal count on the last dma read
	wire we_n_next = ~((strobing & is_mem_wr) |
		(strobing & (kind_now == PCC_CYC_DMA_TO_CARD) & last_reg));
	// i/o strobes double as dma data strobes with the acknowledge
	wire io_read_strobe_n_next = ~(strobing & ((kind_now == PCC_CYC_IO_RD) | (kind_now == PCC_CYC_DMA_TO_HOST)));
	wire io_write_strobe_n_next = ~(strobing & ((kind_now == PCC_CYC_IO_WR) | (kind_now == PCC_CYC_DMA_TO_CARD)));

	// sequencer next state
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			PCC_ST_IDLE:
			begin
				if (take)
				begin
					state_next = PCC_ST_SETUP;
					cnt_next = PCC_CNT_W'(PCC_SETUP_CYC);
				end
			end
			PCC_ST_SETUP:
			begin
				if (cnt_reg == PCC_CNT_ONE)
				begin
					state_next = PCC_ST_STROBE;
					cnt_next = PCC_CNT_W'(PCC_STROBE_CYC);
				end
				else
					cnt_next = cnt_reg - PCC_CNT_ONE;
			end
			PCC_ST_STROBE:
			begin
				// minimum width first, then wait may extend it
				if (cnt_reg == PCC_CNT_ONE)
					state_next = PCC_ST_WAIT;
				else
					cnt_next = cnt_reg - PCC_CNT_ONE;
			end
			PCC_ST_WAIT:
			begin
				// strobe held as long as the card asserts wait
				if (!wait_s)
				begin
					state_next = PCC_ST_HOLD;
					cnt_next = PCC_CNT_W'(PCC_HOLD_CYC);
				end
			end
			PCC_ST_HOLD:
			begin
				if (cnt_reg == PCC_CNT_ONE)
				begin
					state_next = PCC_ST_IDLE;
					cnt_next = PCC_CNT_ZERO;
				end
				else
					cnt_next = cnt_reg - PCC_CNT_ONE;
			end
			default:
			begin
				state_next = PCC_ST_IDLE;
				cnt_next = PCC_CNT_ZERO;
			end
		endcase
	end

	// state, request latch and registered pins
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= PCC_ST_IDLE;
			cnt_reg <= PCC_CNT_ZERO;
			kind_reg <= PCC_CYC_MEM_RD;
			last_reg <= 1'b0;
			reset_reg <= 1'b1; // card held in reset with the host
			attr_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			io_read_strobe_n_reg <= 1'b1;
			io_write_strobe_n_reg <= 1'b1;
			cyc_done <= 1'b0;
		end
		else if (clk_en)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (take)
			begin
				kind_reg <= cyc_kind;
				last_reg <= cyc_last;
			end
			reset_reg <= card_reset_req;
			attr_n_reg <= attr_n_next;
			oe_n_reg <= oe_n_next;
			we_n_reg <= we_n_next;
			io_read_strobe_n_reg <= io_read_strobe_n_next;
			io_write_strobe_n_reg <= io_write_strobe_n_next;
			cyc_done <= (state_reg == PCC_ST_HOLD) && (cnt_reg == PCC_CNT_ONE);
		end
	end

	// pins straight from flip-flops
	assign attr_sel_n = attr_n_reg;
	assign oe_n = oe_n_reg;
	assign we_n = we_n_reg;
	assign io_read_strobe_n = io_read_strobe_n_reg;
	assign io_write_strobe_n = io_write_strobe_n_reg;
	assign card_reset = reset_reg;

endmodule : pcc_ctrl

// ==== verification/pcc_ctrl_checker.sv ====
// port assertions for the card control-signal sequencer
`timescale 1ns/10ps
module pcc_ctrl_checker (
	input wire logic clk_sys, rstn, clk_en, if_mode, card_reset_req, cyc_req, cyc_last, cyc_ready, cyc_done,
	input wire logic [2:0] cyc_kind,
	input wire logic ready_irq_pin, wait_n_pin, wp_pin, voltage_sense_one_in, voltage_sense_two_in,
	input wire logic attr_sel_n, oe_n, we_n, io_read_strobe_n, io_write_strobe_n, card_reset,
	input wire logic card_busy, card_interrupt_request, write_protected,
	input wire logic [1:0] card_voltage
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// request accepted on this edge
	wire take = clk_en && cyc_req && cyc_ready;
	// card never waits and clock keeps running through the cycle
	sequence s_quiet;
		(wait_n_pin && clk_en)[*8] ##1 (wait_n_pin && clk_en)[*6];
	endsequence
	sequence s_taken;
		take ##1 s_quiet;
	endsequence
	a_done_latency: assert property (s_taken |-> ##1 cyc_done) else $error("cycle end late or early");
	a_wait_stretch: assert property ((!oe_n && !wait_n_pin && clk_en)[*4] |=> !oe_n)
		else $error("strobe ended while waiting");
	a_common_high: assert property (take && cyc_kind < 3'h2 |=> attr_sel_n[*8]) else $error("select low");
	a_attr_low: assert property (take && cyc_kind > 3'h1 |-> ##2 !attr_sel_n) else $error("select high");
	a_mem_read: assert property (take && cyc_kind == 3'h0 |-> ##5 !oe_n && we_n && io_read_strobe_n)
		else $error("read strobe wrong");
	a_mem_write: assert property (take && cyc_kind == 3'h1 |-> ##5 !we_n && oe_n) else $error("write strobe");
	a_dma_host: assert property (take && cyc_kind == 3'h6 |-> ##5 !attr_sel_n && !io_read_strobe_n && io_write_strobe_n)
		else $error("dma to host strobes");
	a_dma_card: assert property (take && cyc_kind == 3'h7 && cyc_last |-> ##5 !attr_sel_n && !io_write_strobe_n && !we_n)
		else $error("dma to card strobes");
	a_strobe_width: assert property ($fell(oe_n) |-> (!oe_n)[*8]) else $error("strobe too short");
	a_reset_refuse: assert property (card_reset |-> !cyc_ready) else $error("ready in reset");
	a_reset_follow: assert property (clk_en && card_reset_req |=> card_reset) else $error("no card reset");
	a_busy_mem: assert property ((!if_mode && !ready_irq_pin && clk_en)[*3] |-> card_busy && !cyc_ready)
		else $error("busy not seen");
	a_irq_io: assert property ((if_mode && !ready_irq_pin && clk_en)[*3] |-> card_interrupt_request && !card_busy)
		else $error("irq not seen");
	a_wp_switch: assert property ((!if_mode && wp_pin && clk_en)[*3] |-> write_protected) else $error("wp lost");
	a_volt_pair: assert property ((clk_en && $stable({voltage_sense_two_in, voltage_sense_one_in}))[*3]
		|-> card_voltage == ~{voltage_sense_two_in, voltage_sense_one_in}) else $error("voltage code");
endmodule : pcc_ctrl_checker
bind pcc_ctrl pcc_ctrl_checker u_chk (.*);

// ==== verification/pcc_card_model.sv ====
// behavioural 16-bit card on the control pins
`timescale 1ns/10ps
module pcc_card_model (
	input wire logic clk_sys, busy, irq, stretch, wp_level, oe_n,
	input wire logic [1:0] vs_code,
	input wire logic voltage_sense_one_out, voltage_sense_one_oe, voltage_sense_two_out, voltage_sense_two_oe,
	output logic ready_irq_pin, wait_n_pin, wp_pin, voltage_sense_one_in, voltage_sense_two_in
);
	logic [3:0] wait_cnt_reg = 4'h0; // cycles of wait still to hold
	logic oe_last_reg = 1'b1; // strobe one cycle ago
	assign ready_irq_pin = !(busy || irq);
	assign wp_pin = wp_level;
	assign wait_n_pin = (wait_cnt_reg == 4'h0);
	// pulled-up sense lines, low where card grounds or host drives
	assign voltage_sense_one_in = !vs_code[0] && (voltage_sense_one_oe || voltage_sense_one_out);
	assign voltage_sense_two_in = !vs_code[1] && (voltage_sense_two_oe || voltage_sense_two_out);
	// wait held ten cycles from a falling strobe, long enough to cross the sync
	always @(posedge clk_sys)
	begin
		oe_last_reg <= oe_n;
		if (oe_last_reg && !oe_n && stretch)
			wait_cnt_reg <= 4'ha;
		else if (wait_cnt_reg != 4'h0)
			wait_cnt_reg <= wait_cnt_reg - 4'h1;
	end
endmodule : pcc_card_model

// ==== verification/pcc_ctrl_tb.sv ====
// self-checking bench for the card control-signal sequencer
`timescale 1ns/10ps
module pcc_ctrl_tb
	import pcc_pkg::*;
;
	logic clk_sys = 1'b0, rstn = 1'b0, clk_en = 1'b0, if_mode = 1'b1, card_reset_req = 1'b1, cyc_req = 1'b0;
	logic cyc_last = 1'b1, busy = 1'b0, irq = 1'b0, stretch = 1'b0, wp_level = 1'b0;
	logic [2:0] cyc_kind = 3'h0;
	logic [1:0] vs_code = 2'h0, card_voltage;
	logic cyc_ready, cyc_done, ready_irq_pin, wait_n_pin, wp_pin, voltage_sense_one_in, voltage_sense_two_in;
	logic voltage_sense_one_out, voltage_sense_one_oe, voltage_sense_two_out, voltage_sense_two_oe;
	logic attr_sel_n, oe_n, we_n, io_read_strobe_n, io_write_strobe_n, card_reset, card_busy;
	logic card_interrupt_request, write_protected, wide_io_port_indicator, dma_request;
	logic [4:0] pins; // strobes seen mid-cycle
	int fails = 0, comparisons = 0, n;
	// edges from take until cyc_done shows: setup, strobe, one wait check, hold
	localparam int BASE_CYC = PCC_SETUP_CYC + PCC_STROBE_CYC + 1 + PCC_HOLD_CYC;
	pcc_ctrl u_dut (.*);
	pcc_card_model u_card (.*);
	// 50 mhz system clock
	always #10 clk_sys = ~clk_sys;
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// one request; strobes sampled mid-strobe, n counts edges from take to done
	task automatic run_cycle(input logic [2:0] kind);
		@(posedge clk_sys);
		cyc_req <= 1'b1;
		cyc_kind <= kind;
		@(posedge clk_sys);
		cyc_req <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 pins = {attr_sel_n, oe_n, we_n, io_read_strobe_n, io_write_strobe_n};
		for (n = 5; cyc_done !== 1'b1 && n < 100; n++)
			@(posedge clk_sys) #1;
		// done stands for one cycle only
		@(posedge clk_sys) #1 check(cyc_done, 8'h00);
	endtask : run_cycle
	task automatic t_reset;
		#1 check({card_reset, cyc_ready}, 8'h02);
		@(posedge clk_sys);
		card_reset_req <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 check({card_reset, cyc_ready}, 8'h01);
		$display("reset test done");
	endtask : t_reset
	task automatic t_kinds;
		logic [4:0] want;
		for (int k = 0; k < 8; k++)
		begin
			run_cycle(k[2:0]);
			want = {k < 2, !(k == 0 || k == 2), !(k == 1 || k == 3 || k == 7), !(k == 4 || k == 6), !(k == 5 || k == 7)};
			check(pins, want);
			check(n, 8'(BASE_CYC));
		end
		@(posedge clk_sys);
		cyc_last <= 1'b0;
		run_cycle(3'h7);
		check(pins, 5'h0e);
		$display("cycle kinds test done");
	endtask : t_kinds
	// clock enable low holds strobes and stretches the cycle by the frozen edges
	task automatic t_freeze;
		@(posedge clk_sys);
		cyc_req <= 1'b1;
		cyc_kind <= 3'h4;
		@(posedge clk_sys);
		cyc_req <= 1'b0;
		repeat (5) @(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (5) @(posedge clk_sys);
		clk_en <= 1'b1;
		#1 check({attr_sel_n, oe_n, we_n, io_read_strobe_n, io_write_strobe_n}, 8'h0d);
		for (n = 10; cyc_done !== 1'b1 && n < 100; n++)
			@(posedge clk_sys) #1;
		check(n, 8'(BASE_CYC + 5));
		$display("clock enable test done");
	endtask : t_freeze
	// reset in mid-cycle releases every strobe at once, then the socket recovers
	task automatic t_midreset;
		@(posedge clk_sys);
		cyc_req <= 1'b1;
		cyc_kind <= 3'h5;
		@(posedge clk_sys);
		cyc_req <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b0;
		#1 check({attr_sel_n, oe_n, we_n, io_read_strobe_n, io_write_strobe_n, card_reset, cyc_done}, 8'h7e);
		@(posedge clk_sys);
		rstn <= 1'b1;
		#1 check({card_reset, cyc_ready}, 8'h02);
		repeat (2) @(posedge clk_sys);
		#1 check({card_reset, cyc_ready}, 8'h01);
		run_cycle(3'h5);
		check(pins, 5'h0e);
		check(n, 8'(BASE_CYC));
		$display("mid-run reset test done");
	endtask : t_midreset
	task automatic t_wait;
		@(posedge clk_sys);
		if_mode <= 1'b0;
		stretch <= 1'b1;
		run_cycle(3'h0);
		check(n > BASE_CYC, 8'h01);
		@(posedge clk_sys);
		stretch <= 1'b0;
		$display("wait test done");
	endtask : t_wait
	task automatic t_busy;
		@(posedge clk_sys);
		busy <= 1'b1;
		// request only once busy has crossed the synchroniser
		repeat (3) @(posedge clk_sys);
		cyc_req <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 check({card_busy, card_interrupt_request, cyc_ready, oe_n}, 8'h09);
		repeat (12) @(posedge clk_sys);
		#1 check({card_busy, card_interrupt_request, cyc_ready, oe_n}, 8'h09);
		@(posedge clk_sys);
		cyc_req <= 1'b0;
		busy <= 1'b0;
		repeat (4) @(posedge clk_sys);
		run_cycle(3'h0);
		check(n, 8'(BASE_CYC));
		$display("busy test done");
	endtask : t_busy
	task automatic t_irq;
		@(posedge clk_sys);
		if_mode <= 1'b1;
		irq <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 check({card_busy, card_interrupt_request, cyc_ready}, 8'h03);
		@(posedge clk_sys);
		irq <= 1'b0;
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_wp_volt;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_sys);
			if_mode <= k[1];
			wp_level <= k[0];
			vs_code <= k[1:0];
			repeat (4) @(posedge clk_sys);
			#1 check({write_protected, wide_io_port_indicator, dma_request}, {!k[1] && k[0], k[1] && !k[0], k[0]});
			check({voltage_sense_one_out, voltage_sense_two_out, voltage_sense_one_oe, voltage_sense_two_oe, card_voltage},
				{4'h3, k[1:0]});
		end
		$display("sense test done");
	endtask : t_wp_volt
	// watchdog: the tests need some 330 cycles, allow 2000
	initial
	begin
		#40000;
		fails++;
		report_and_stop;
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		clk_en <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_kinds;
		t_freeze;
		t_midreset;
		t_wait;
		t_busy;
		t_irq;
		t_wp_volt;
		report_and_stop;
	end
endmodule : pcc_ctrl_tb
